/* esxs_consts.svh */
// Register offsets, field positions, reset values and counts of the sleep-capable serial block.
`ifndef ESXS_CONSTS_SVH
`define ESXS_CONSTS_SVH

`define ESXS_OFF_CTRL 12'h000
`define ESXS_OFF_TXDATA 12'h004
`define ESXS_OFF_RXDATA 12'h008
`define ESXS_OFF_STATUS 12'h00C
`define ESXS_OFF_IRQ_STAT 12'h010
`define ESXS_OFF_IRQ_MASK 12'h014
`define ESXS_OFF_INT_CTRL 12'h018
`define ESXS_OFF_PIN_A 12'h01C
`define ESXS_OFF_PIN_B 12'h020
`define ESXS_OFF_SLEEP 12'h024

`define ESXS_CTRL_EN 0
`define ESXS_CTRL_SYNC 1
`define ESXS_CTRL_SLAVE 2
`define ESXS_CTRL_RXEN 3
`define ESXS_CTRL_TXEN 4

`define ESXS_ST_RCF 0
`define ESXS_ST_TRF 1
`define ESXS_ST_BUSY 2
`define ESXS_ST_SLEEP 3

`define ESXS_IRQ_RX 0
`define ESXS_IRQ_TX 1
`define ESXS_IRQ_OVR 2

`define ESXS_IE_RC 0
`define ESXS_IE_TX 1
`define ESXS_IE_PERI 2
`define ESXS_IE_GLOB 3

`define ESXS_RST_CTRL 5'h00
`define ESXS_RST_INTEN 4'h0
`define ESXS_RST_IRQ 3'h0
`define ESXS_RST_BYTE 8'h00

`define ESXS_LAST_BIT 3'h7

`endif

/* esxs_core.sv */
// Synchronous slave serial transceiver that keeps shifting while the processor sleeps.
//
// Notes on behaviour
// - In sleep, only the synchronous slave configuration shifts; other modes stay idle.
// - Shift registers advance only on edges of the master's clock pin.
// - Receiving in sleep, the data pin is an input clocked by the pin clock.
// - A completed received word sets the receive complete flag, which requests wake.
// - Transmitting in sleep, the device drives data on the master's clock.
// - After a word leaves, the held byte moves in and transmit ready sets.
// - Writing the holding register clears transmit ready, unless an idle enabled transmitter takes the byte at once.
// - Wake resumes after sleep; with global enable the vector is taken.
// - Data and clock pins relocate by two registers; reset picks default spots.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "esxs_consts.svh"
module esxs_core (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Processor side.
    output logic irq_o,
    output logic resume_o,
    output logic vector_o,
    // Serial data pin, default and alternate location.
    input wire logic data_a_i,
    output logic data_a_o,
    output logic data_a_oe_n_o,
    input wire logic data_b_i,
    output logic data_b_o,
    output logic data_b_oe_n_o,
    // Serial clock pin from the master, default and alternate location.
    input wire logic clk_a_i,
    input wire logic clk_b_i
);
    esxs_pkg::esxs_state_t s_q;
    esxs_pkg::esxs_state_t s_d;

    logic [3:0] pin_raw;
    logic [3:0] pin_sync;
    logic clk_sel;
    logic data_in;
    logic rise;
    logic fall;
    logic sync_slave;
    logic rx_on;
    logic tx_on;
    logic wake_cond;
    logic acc;
    logic commit;
    logic wr;
    logic rd;
    logic rx_done;
    logic rx_load;
    logic tx_ev;
    logic ovr_ev;

    assign pin_raw = {clk_b_i, clk_a_i, data_b_i, data_a_i};

    // Every pin is asynchronous to ref_clk_i, so each passes two flops first.
    for (genvar i = 0; i < 4; i++) begin : g_sync
        esxs_sync u_sync (
            .ref_clk_i(ref_clk_i),
            .resetn_i(resetn_i),
            .d_i(pin_raw[i]),
            .q_o(pin_sync[i])
        );
    end

    assign clk_sel = s_q.pin_clk_alt ? pin_sync[3] : pin_sync[2];
    assign data_in = s_q.pin_data_alt ? pin_sync[1] : pin_sync[0];
    // Edges are found on the sampled pin clock; the master clock must stay well below
    // half of ref_clk_i or edges are missed.
    assign rise = clk_sel & ~s_q.clk_prev;
    assign fall = ~clk_sel & s_q.clk_prev;

    // Master and asynchronous modes need the stopped system clock and are not built here.
    assign sync_slave = s_q.ctrl[`ESXS_CTRL_EN] & s_q.ctrl[`ESXS_CTRL_SYNC]
        & s_q.ctrl[`ESXS_CTRL_SLAVE];
    assign rx_on = sync_slave & s_q.ctrl[`ESXS_CTRL_RXEN];
    assign tx_on = sync_slave & s_q.ctrl[`ESXS_CTRL_TXEN] & ~s_q.ctrl[`ESXS_CTRL_RXEN];

    // Pure gating of flags and enables, so a stopped core clock could still see it.
    assign wake_cond = s_q.inten[`ESXS_IE_PERI]
        & ((s_q.rx_full & s_q.inten[`ESXS_IE_RC])
        | (~s_q.thr_full & s_q.inten[`ESXS_IE_TX]));

    assign acc = psel_i & penable_i;
    assign commit = acc & s_q.pready;
    assign wr = commit & pwrite_i & ~s_q.pslverr;
    assign rd = commit & ~pwrite_i & ~s_q.pslverr;

    always_comb begin
        logic hit;
        logic [31:0] rval;
        hit = 1'b1;
        rval = 32'h00000000;
        s_d = s_q;
        rx_done = 1'b0;
        rx_load = 1'b0;
        tx_ev = 1'b0;
        ovr_ev = 1'b0;
        s_d.resume = 1'b0;
        s_d.vector = 1'b0;
        s_d.clk_prev = clk_sel;

        // Read mux, sampled one cycle before the answer.
        case (paddr_i)
            `ESXS_OFF_CTRL: rval = {27'h0, s_q.ctrl};
            `ESXS_OFF_TXDATA: rval = {24'h000000, s_q.thr};
            `ESXS_OFF_RXDATA: rval = {24'h000000, s_q.rx_buf};
            `ESXS_OFF_STATUS: begin
                rval[`ESXS_ST_RCF] = s_q.rx_full;
                rval[`ESXS_ST_TRF] = ~s_q.thr_full;
                rval[`ESXS_ST_BUSY] = (s_q.tx_state == esxs_pkg::ESXS_TX_SHIFT);
                rval[`ESXS_ST_SLEEP] = s_q.sleep;
            end
            `ESXS_OFF_IRQ_STAT: rval = {29'h0, s_q.irq_stat};
            `ESXS_OFF_IRQ_MASK: rval = {29'h0, s_q.irq_mask};
            `ESXS_OFF_INT_CTRL: rval = {28'h0, s_q.inten};
            `ESXS_OFF_PIN_A: rval = {31'h0, s_q.pin_data_alt};
            `ESXS_OFF_PIN_B: rval = {31'h0, s_q.pin_clk_alt};
            `ESXS_OFF_SLEEP: rval = {31'h0, s_q.sleep};
            default: hit = 1'b0;
        endcase

        // One wait state: pready rises in the second access cycle.
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (acc & ~s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~hit;
            s_d.prdata = hit ? rval : 32'h00000000;
        end

        // Software writes; hardware sets below win over these clears.
        if (wr) begin
            case (paddr_i)
                `ESXS_OFF_CTRL: s_d.ctrl = pwdata_i[4:0];
                `ESXS_OFF_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~pwdata_i[2:0];
                `ESXS_OFF_IRQ_MASK: s_d.irq_mask = pwdata_i[2:0];
                `ESXS_OFF_INT_CTRL: s_d.inten = pwdata_i[3:0];
                `ESXS_OFF_PIN_A: s_d.pin_data_alt = pwdata_i[0];
                `ESXS_OFF_PIN_B: s_d.pin_clk_alt = pwdata_i[0];
                `ESXS_OFF_SLEEP: s_d.sleep = s_q.sleep | pwdata_i[0];
                default: ;
            endcase
        end
        if (rd && paddr_i == `ESXS_OFF_RXDATA) begin
            s_d.rx_full = 1'b0;
        end

        // Receiver.
        if (!rx_on) begin
            s_d.rx_cnt = 3'h0;
        end else if (rise) begin
            s_d.rx_shift = {data_in, s_q.rx_shift[7:1]};
            s_d.rx_cnt = s_q.rx_cnt + 3'h1;
            if (s_q.rx_cnt == `ESXS_LAST_BIT) begin
                rx_done = 1'b1;
                if (s_d.rx_full) begin
                    ovr_ev = 1'b1;
                end else begin
                    rx_load = 1'b1;
                    s_d.rx_buf = {data_in, s_q.rx_shift[7:1]};
                    s_d.rx_full = 1'b1;
                end
            end
        end

        // Transmitter: bit 0 of the shift register is on the pin; it moves on each fall.
        case (s_q.tx_state)
            esxs_pkg::ESXS_TX_IDLE: begin
                if (tx_on && s_q.thr_full) begin
                    s_d.transmit_shift_register = s_q.thr;
                    s_d.thr_full = 1'b0;
                    s_d.tx_cnt = 3'h0;
                    s_d.tx_state = esxs_pkg::ESXS_TX_SHIFT;
                    tx_ev = 1'b1;
                end
            end
            esxs_pkg::ESXS_TX_SHIFT: begin
                if (!tx_on) begin
                    s_d.tx_state = esxs_pkg::ESXS_TX_IDLE;
                end else if (fall) begin
                    if (s_q.tx_cnt == `ESXS_LAST_BIT) begin
                        s_d.tx_cnt = 3'h0;
                        if (s_q.thr_full) begin
                            s_d.transmit_shift_register = s_q.thr;
                            s_d.thr_full = 1'b0;
                            tx_ev = 1'b1;
                        end else begin
                            s_d.tx_state = esxs_pkg::ESXS_TX_IDLE;
                        end
                    end else begin
                        s_d.transmit_shift_register = {1'b1, s_q.transmit_shift_register[7:1]};
                        s_d.tx_cnt = s_q.tx_cnt + 3'h1;
                    end
                end
            end
            default: s_d.tx_state = esxs_pkg::ESXS_TX_IDLE;
        endcase
        if (wr && paddr_i == `ESXS_OFF_TXDATA) begin
            if (tx_on && s_d.tx_state == esxs_pkg::ESXS_TX_IDLE && !s_q.thr_full) begin
                s_d.transmit_shift_register = pwdata_i[7:0];
                s_d.tx_cnt = 3'h0;
                s_d.tx_state = esxs_pkg::ESXS_TX_SHIFT;
            end else begin
                // A write onto a still full holding register replaces the old byte.
                s_d.thr = pwdata_i[7:0];
                s_d.thr_full = 1'b1;
            end
        end

        // Pin drive; the unused location is released, the line idles high.
        s_d.data_a_oe_n = ~(tx_on & ~s_q.pin_data_alt);
        s_d.data_b_oe_n = ~(tx_on & s_q.pin_data_alt);
        s_d.data_a = (s_d.tx_state == esxs_pkg::ESXS_TX_SHIFT) ? s_d.transmit_shift_register[0] : 1'b1;
        s_d.data_b = s_d.data_a;

        // Sticky events, set wins over the write-one clear.
        s_d.irq_stat[`ESXS_IRQ_RX] = s_d.irq_stat[`ESXS_IRQ_RX] | rx_load;
        s_d.irq_stat[`ESXS_IRQ_TX] = s_d.irq_stat[`ESXS_IRQ_TX] | tx_ev;
        s_d.irq_stat[`ESXS_IRQ_OVR] = s_d.irq_stat[`ESXS_IRQ_OVR] | ovr_ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // Wake: a sleep request made while a wake source is active falls straight through.
        if (s_d.sleep && wake_cond) begin
            s_d.sleep = 1'b0;
            s_d.resume = 1'b1;
            s_d.vector = s_q.inten[`ESXS_IE_GLOB];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.ctrl <= `ESXS_RST_CTRL;
            s_q.inten <= `ESXS_RST_INTEN;
            s_q.irq_stat <= `ESXS_RST_IRQ;
            s_q.irq_mask <= `ESXS_RST_IRQ;
            s_q.thr <= `ESXS_RST_BYTE;
            s_q.transmit_shift_register <= `ESXS_RST_BYTE;
            s_q.tx_state <= esxs_pkg::ESXS_TX_IDLE;
            s_q.data_a <= 1'b1;
            s_q.data_b <= 1'b1;
            s_q.data_a_oe_n <= 1'b1;
            s_q.data_b_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign irq_o = s_q.irq;
    assign resume_o = s_q.resume;
    assign vector_o = s_q.vector;
    assign data_a_o = s_q.data_a;
    assign data_a_oe_n_o = s_q.data_a_oe_n;
    assign data_b_o = s_q.data_b;
    assign data_b_oe_n_o = s_q.data_b_oe_n;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_word_end;
        rx_on && rise && s_q.rx_cnt == 3'h7 && !s_q.rx_full;
    endsequence

    sequence s_tx_last_fall;
        s_q.tx_state == esxs_pkg::ESXS_TX_SHIFT && tx_on && fall && s_q.tx_cnt == 3'h7;
    endsequence

    a_idle_mode_static: assert property (!sync_slave |=> s_q.rx_cnt == 3'h0
        && s_q.tx_state == esxs_pkg::ESXS_TX_IDLE)
        else $error("shifter active outside sync slave mode");
    a_shift_on_edge: assert property ($changed(s_q.rx_cnt) && $past(rx_on)
        |-> $past(rise))
        else $error("receive count moved without clock rise");
    a_rx_pin_input: assert property (rx_on |=> s_q.data_a_oe_n && s_q.data_b_oe_n)
        else $error("data pin driven while receiving");
    a_rx_flag_set: assert property (s_word_end |=> s_q.rx_full
        && s_q.rx_buf == {$past(data_in), $past(s_q.rx_shift[7:1])})
        else $error("receive flag not set after word");
    a_tx_drive_pin: assert property (tx_on && !s_q.pin_data_alt |=> !s_q.data_a_oe_n
        && s_q.data_b_oe_n)
        else $error("transmit pin not driven");
    a_tx_move_held: assert property (s_tx_last_fall and s_q.thr_full
        && !(wr && paddr_i == `ESXS_OFF_TXDATA)
        |=> !s_q.thr_full && s_q.transmit_shift_register == $past(s_q.thr)
        && s_q.irq_stat[`ESXS_IRQ_TX])
        else $error("held byte not moved into shift register");
    a_write_clears_ready: assert property (wr && paddr_i == `ESXS_OFF_TXDATA
        && s_q.tx_state == esxs_pkg::ESXS_TX_SHIFT && !fall |=> s_q.thr_full)
        else $error("holding write left transmit ready set");
    a_wake_resume: assert property (s_q.sleep && wake_cond |=> !s_q.sleep && resume_o
        && vector_o == $past(s_q.inten[`ESXS_IE_GLOB]) ##1 !resume_o)
        else $error("wake did not resume exactly once");
    a_pin_alt_release: assert property (s_q.pin_data_alt |=> data_a_oe_n_o)
        else $error("default data pin driven while relocated");
    a_wake_gating: assert property (s_q.sleep && !s_q.inten[`ESXS_IE_PERI]
        && !(wr && paddr_i == `ESXS_OFF_INT_CTRL) |=> !resume_o)
        else $error("wake without peripheral enable");
endmodule

/* esxs_master.sv */
// Behavioural model of the external synchronous master that clocks the serial link.
`timescale 1ns/100ps
module esxs_master (
    // Link lines towards the device.
    output logic sclk_o,
    output logic sdata_o,
    input wire logic sdata_i
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b1;
    end

    // The clock stands low between frames, so the device never sees a stray edge.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        // The odd offset keeps every link edge away from the system clock edges.
        #3.2;
        for (int i = 0; i < 8; i++) begin
            sdata_o = tx[i];
            #62.5;
            sclk_o = 1'b1;
            rx[i] = sdata_i;
            #62.5;
            sclk_o = 1'b0;
        end
        // The line is released after the frame; show a changed level, not the last bit.
        sdata_o = ~tx[7];
    endtask
endmodule

/* esxs_pkg.sv */
// Types shared by the sleep-capable serial block.
package esxs_pkg;

    typedef enum logic {
        ESXS_TX_IDLE,
        ESXS_TX_SHIFT
    } esxs_tx_state_t;

    typedef struct packed {
        logic [4:0] ctrl;
        logic [3:0] inten;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic pin_data_alt;
        logic pin_clk_alt;
        logic sleep;
        logic clk_prev;
        logic [7:0] rx_shift;
        logic [2:0] rx_cnt;
        logic [7:0] rx_buf;
        logic rx_full;
        esxs_tx_state_t tx_state;
        logic [7:0] transmit_shift_register;
        logic [2:0] tx_cnt;
        logic [7:0] thr;
        logic thr_full;
        logic data_a;
        logic data_a_oe_n;
        logic data_b;
        logic data_b_oe_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic resume;
        logic vector;
    } esxs_state_t;

endpackage

/* esxs_sync.sv */
// Two-flop synchroniser for one pin input.
`timescale 1ns/100ps
module esxs_sync (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Pin level in, synchronised level out.
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* usart_sync_slave_sleep_operation_tb.sv */
// Self-checking bench for the sleep-capable synchronous slave serial block.
`timescale 1ns/100ps
`include "esxs_consts.svh"
module usart_sync_slave_sleep_operation_tb;
    logic ref_clk_i;
    logic resetn_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic resume;
    logic vector;
    logic da_o;
    logic da_oe_n;
    logic db_o;
    logic db_oe_n;
    logic dsel;
    logic csel;
    logic sclk;
    logic mdata;
    logic line_a;
    logic line_b;
    logic wake_vec = 1'b0;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] rx;
    int wakes = 0;
    int err_total;
    int samples_checked;
    int seed;

    // Each pin location resolves to the device when it drives, else to the master, inverted at the location that dsel does not select.
    assign line_a = (da_oe_n === 1'b0) ? da_o : (dsel ? ~mdata : mdata);
    assign line_b = (db_oe_n === 1'b0) ? db_o : (dsel ? mdata : ~mdata);

    esxs_core dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .resume_o(resume), .vector_o(vector),
        .data_a_i(line_a), .data_a_o(da_o), .data_a_oe_n_o(da_oe_n),
        .data_b_i(line_b), .data_b_o(db_o), .data_b_oe_n_o(db_oe_n),
        .clk_a_i(csel ? 1'b0 : sclk), .clk_b_i(csel ? sclk : 1'b0)
    );

    esxs_master ms (
        .sclk_o(sclk),
        .sdata_o(mdata),
        .sdata_i(dsel ? line_b : line_a)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // Resume pulses last one cycle, so they are counted here rather than polled.
    always @(posedge ref_clk_i) begin
        if (resume === 1'b1) begin
            wakes <= wakes + 1;
            wake_vec <= vector;
        end
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel in this time step.
        @(posedge ref_clk_i);
        if (n >= 20) begin
            chk(32'h0, 32'h1, "bus timeout");
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd & mk, e, "register read");
        chk({31'h0, er}, 32'h0, "slave error");
    endtask

    task automatic wait_wake(input int n0, input logic v);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (wakes == n0 && n < 200) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(wakes - n0, 32'h1, "wake count");
        chk({31'h0, wake_vec}, {31'h0, v}, "vector");
        if (wakes == n0) begin
            stop_test();
        end
    endtask

    initial begin
        logic [31:0] rd;
        logic er;
        int n0;
        logic g;
        seed = 32;
        err_total = 0;
        samples_checked = 0;
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dsel = 1'b0;
        csel = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd_chk(`ESXS_OFF_STATUS, 32'h2, 32'hFFFFFFFB);
        rd_chk(`ESXS_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
        rd_chk(`ESXS_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF);
        rd_chk(`ESXS_OFF_PIN_A, 32'h0, 32'hFFFFFFFF);
        rd_chk(`ESXS_OFF_PIN_B, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 12'h0FC, 32'h0, rd, er);
        chk({rd[31:1], er}, 32'h1, "unmapped access");
        chk({31'h0, irq}, 32'h0, "irq after reset");
        $display("Test reset values done");
        // Receive enabled but not slave: the frame must be ignored.
        wr(`ESXS_OFF_CTRL, 32'h0B);
        ms.xfer(8'hA5, rx);
        repeat (8) @(posedge ref_clk_i);
        rd_chk(`ESXS_OFF_STATUS, 32'h0, 32'h1);
        chk({31'h0, da_oe_n}, 32'h1, "data pin driven");
        $display("Test wrong mode done");
        for (int k = 0; k < 6; k++) begin
            b0 = 8'($random(seed));
            g = k[0];
            dsel <= (k >= 4);
            csel <= (k >= 4);
            wr(`ESXS_OFF_PIN_A, {31'h0, k >= 4});
            wr(`ESXS_OFF_PIN_B, {31'h0, k >= 4});
            wr(`ESXS_OFF_CTRL, 32'h0F);
            wr(`ESXS_OFF_INT_CTRL, {28'h0, g, 3'b101});
            wr(`ESXS_OFF_IRQ_MASK, 32'h1);
            rd_chk(`ESXS_OFF_STATUS, 32'h0, 32'h1);
            n0 = wakes;
            wr(`ESXS_OFF_SLEEP, 32'h1);
            rd_chk(`ESXS_OFF_STATUS, 32'h8, 32'h9);
            ms.xfer(b0, rx);
            wait_wake(n0, g);
            chk({31'h0, irq}, 32'h1, "rx irq");
            rd_chk(`ESXS_OFF_RXDATA, {24'h0, b0}, 32'hFFFFFFFF);
            rd_chk(`ESXS_OFF_STATUS, 32'h0, 32'h9);
            wr(`ESXS_OFF_IRQ_STAT, 32'h1);
            repeat (2) @(posedge ref_clk_i);
            chk({31'h0, irq}, 32'h0, "irq cleared");
        end
        // A second word while the first is unread is dropped and flags an overrun.
        b1 = 8'($random(seed));
        ms.xfer(b1, rx);
        ms.xfer(~b1, rx);
        repeat (8) @(posedge ref_clk_i);
        rd_chk(`ESXS_OFF_IRQ_STAT, 32'h5, 32'hFFFFFFFF);
        rd_chk(`ESXS_OFF_RXDATA, {24'h0, b1}, 32'hFFFFFFFF);
        wr(`ESXS_OFF_IRQ_STAT, 32'h7);
        rd_chk(`ESXS_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF);
        $display("Test sleep receive done");
        dsel <= 1'b0;
        csel <= 1'b0;
        wr(`ESXS_OFF_PIN_A, 32'h0);
        wr(`ESXS_OFF_PIN_B, 32'h0);
        wr(`ESXS_OFF_CTRL, 32'h17);
        wr(`ESXS_OFF_INT_CTRL, 32'h6);
        wr(`ESXS_OFF_IRQ_MASK, 32'h2);
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        wr(`ESXS_OFF_TXDATA, {24'h0, b0});
        wr(`ESXS_OFF_TXDATA, {24'h0, b1});
        rd_chk(`ESXS_OFF_STATUS, 32'h0, 32'h2);
        n0 = wakes;
        wr(`ESXS_OFF_SLEEP, 32'h1);
        chk({31'h0, da_oe_n}, 32'h0, "device drives data");
        ms.xfer(8'h00, rx);
        chk({24'h0, rx}, {24'h0, b0}, "first sent byte");
        wait_wake(n0, 1'b0);
        rd_chk(`ESXS_OFF_STATUS, 32'h2, 32'h2);
        rd_chk(`ESXS_OFF_IRQ_STAT, 32'h2, 32'hFFFFFFFF);
        chk({31'h0, irq}, 32'h1, "tx irq");
        ms.xfer(8'hFF, rx);
        chk({24'h0, rx}, {24'h0, b1}, "second sent byte");
        $display("Test sleep transmit done");
        stop_test();
    end
endmodule
